// ### logic/bedo_addr_mux.sv
`timescale 1ns/1ps
`default_nettype none

module bedo_addr_mux (
	input  wire logic                                clk_sys,
	input  wire logic                                reset,
	input  wire logic                                use_col,
	input  wire logic [bedo_seq_pkg::ADDR_W-1:0]     addr,
	output logic      [bedo_seq_pkg::DRAM_A_W-1:0]   dram_addr
);

	// ----------------------------------------------------------------
	// row / column select
	// ----------------------------------------------------------------
	wire logic [bedo_seq_pkg::DRAM_A_W-1:0] row_part;
	wire logic [bedo_seq_pkg::DRAM_A_W-1:0] col_part;
	wire logic [bedo_seq_pkg::DRAM_A_W-1:0] mux_d;
	logic      [bedo_seq_pkg::DRAM_A_W-1:0] mux_q;

	assign row_part  = addr[bedo_seq_pkg::ROW_LSB +: bedo_seq_pkg::DRAM_A_W];
	assign col_part  = addr[bedo_seq_pkg::COL_LSB +: bedo_seq_pkg::DRAM_A_W];
	assign mux_d     = use_col ? col_part : row_part;
	assign dram_addr = mux_q;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			mux_q <= bedo_seq_pkg::DADDR_ZERO;
		end else begin
			mux_q <= mux_d;
		end
	end

endmodule

`default_nettype wire

// ### logic/bedo_dram_burst_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module bedo_dram_burst_sequencer (
	input  wire logic                                 clk_sys,
	input  wire logic                                 reset,
	input  wire bedo_seq_pkg::cpu_req_type            cpu,
	input  wire logic [bedo_seq_pkg::DATA_W-1:0]      cpu_wdata,
	output logic      [bedo_seq_pkg::DATA_W-1:0]      cpu_rdata,
	output logic                                      cpu_wait_n,
	output bedo_seq_pkg::dram_ctl_type                dram_ctl,
	output logic      [bedo_seq_pkg::DRAM_A_W-1:0]    dram_addr,
	input  wire logic [bedo_seq_pkg::DATA_W-1:0]      dram_dq_in,
	output logic      [bedo_seq_pkg::DATA_W-1:0]      dram_dq_out,
	output logic                                      dram_dq_oe_n
);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// beats left in the dram block after this one; line fills always 3
	function automatic logic [bedo_seq_pkg::BCNT_W-1:0] bcnt_load(
		input logic                              clf,
		input logic [bedo_seq_pkg::ADDR_W-1:0]   a
	);
		logic [bedo_seq_pkg::BCNT_W-1:0] off;
		off = a[bedo_seq_pkg::BEAT_LSB +: bedo_seq_pkg::BCNT_W];
		if (clf) begin
			bcnt_load = bedo_seq_pkg::BCNT_LINE;
		end else begin
			bcnt_load = bedo_seq_pkg::BCNT_LINE - off;
		end
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	bedo_seq_pkg::seq_state_type state_q, state_d;
	logic [bedo_seq_pkg::ADDR_W-1:0] addr_q, addr_d;
	logic [bedo_seq_pkg::LANES-1:0]  be_q, be_d;
	logic                            write_q, write_d;
	logic                            clf_q, clf_d;
	logic                            aborted_q, aborted_d;
	logic [bedo_seq_pkg::BCNT_W-1:0] bcnt_q, bcnt_d;
	logic [bedo_seq_pkg::TMR_W-1:0]  tmr_q, tmr_d;
	bedo_seq_pkg::dram_ctl_type      ctl_q, ctl_d;
	logic [bedo_seq_pkg::DATA_W-1:0] rdata_q, rdata_d;
	logic [bedo_seq_pkg::DATA_W-1:0] wdout_q, wdout_d;
	logic                            oe_n_q, oe_n_d;
	logic                            wait_n_q, wait_n_d;

	wire logic cont;
	wire logic bcnt_zero;
	wire logic rcd_done;
	wire logic rp_done;
	wire logic use_col_d;
	wire logic cas_all_d;
	wire logic cas_lane_d;
	wire logic beat_done;

	assign cont      = cpu.mreq && cpu.seq && (cpu.write == write_q);
	assign bcnt_zero = (bcnt_q == bedo_seq_pkg::BCNT_ZERO);
	assign rcd_done  = (tmr_q == 4'(bedo_seq_pkg::RCD_CYC - 1));
	assign rp_done   = (tmr_q == 4'(bedo_seq_pkg::RP_CYC - 1));
	// read strobes hit every lane; write strobes only the enabled ones
	assign cas_all_d  = !write_q && (state_d == bedo_seq_pkg::ST_COL || state_d == bedo_seq_pkg::ST_RDBEAT);
	assign cas_lane_d = write_q && (state_d == bedo_seq_pkg::ST_COL || state_d == bedo_seq_pkg::ST_WCAS);
	assign use_col_d  = cas_all_d || cas_lane_d;
	// a beat ends on a data strobe; the address-only read strobe is not one
	assign beat_done  = (state_q == bedo_seq_pkg::ST_RDBEAT) || (state_q == bedo_seq_pkg::ST_WCAS)
		|| (write_q && state_q == bedo_seq_pkg::ST_COL);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			bedo_seq_pkg::ST_IDLE: begin
				if (cpu.mreq) begin
					state_d = bedo_seq_pkg::ST_ROW;
				end
			end
			bedo_seq_pkg::ST_ROW: begin
				if (rcd_done) begin
					state_d = bedo_seq_pkg::ST_COL;
				end
			end
			bedo_seq_pkg::ST_COL: begin
				state_d = write_q ? bedo_seq_pkg::ST_ABORT : bedo_seq_pkg::ST_RDBEAT;
			end
			bedo_seq_pkg::ST_RDBEAT: begin
				state_d = bedo_seq_pkg::ST_NEXT;
			end
			bedo_seq_pkg::ST_WCAS: begin
				state_d = bedo_seq_pkg::ST_ABORT;
			end
			bedo_seq_pkg::ST_ABORT: begin
				state_d = bedo_seq_pkg::ST_NEXT;
			end
			bedo_seq_pkg::ST_NEXT: begin
				// read pulse still showing: the next request is not on the bus yet
				if (wait_n_q) begin
					state_d = bedo_seq_pkg::ST_NEXT;
				end else if (write_q) begin
					state_d = cont ? bedo_seq_pkg::ST_WSTL1 : bedo_seq_pkg::ST_PRE;
				end else if (cont) begin
					if (aborted_q) begin
						state_d = bedo_seq_pkg::ST_COL;
					end else if (bcnt_zero) begin
						state_d = bedo_seq_pkg::ST_ABORT;
					end else begin
						state_d = bedo_seq_pkg::ST_RDBEAT;
					end
				end else if (clf_q && bcnt_zero && !aborted_q) begin
					state_d = bedo_seq_pkg::ST_ABORT;
				end else begin
					state_d = bedo_seq_pkg::ST_PRE;
				end
			end
			bedo_seq_pkg::ST_WSTL1: begin
				state_d = bedo_seq_pkg::ST_WSTL2;
			end
			bedo_seq_pkg::ST_WSTL2: begin
				state_d = bedo_seq_pkg::ST_WCAS;
			end
			bedo_seq_pkg::ST_PRE: begin
				if (rp_done) begin
					state_d = bedo_seq_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = bedo_seq_pkg::ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// datapath and strobes
	// ----------------------------------------------------------------
	always_comb begin
		addr_d    = addr_q;
		be_d      = be_q;
		write_d   = write_q;
		clf_d     = clf_q;
		bcnt_d    = bcnt_q;
		aborted_d = aborted_q;
		if (state_q == bedo_seq_pkg::ST_IDLE && cpu.mreq) begin
			addr_d  = cpu.addr;
			be_d    = cpu.byte_en;
			write_d = cpu.write;
			clf_d   = cpu.clf;
			bcnt_d  = bcnt_load(cpu.clf && !cpu.write, cpu.addr);
		end
		if (state_q == bedo_seq_pkg::ST_NEXT && cont) begin
			addr_d = cpu.addr;
			be_d   = cpu.byte_en;
			if (state_d == bedo_seq_pkg::ST_COL) begin
				bcnt_d = bcnt_load(clf_q, cpu.addr);
			end
		end
		if (state_q == bedo_seq_pkg::ST_NEXT && state_d == bedo_seq_pkg::ST_RDBEAT) begin
			bcnt_d = bcnt_q - 2'h1;
		end
		if (state_q == bedo_seq_pkg::ST_ABORT) begin
			aborted_d = 1'b1;
		end else if (state_q == bedo_seq_pkg::ST_NEXT || state_q == bedo_seq_pkg::ST_IDLE) begin
			aborted_d = 1'b0;
		end
	end

	assign tmr_d = (state_d != state_q) ? bedo_seq_pkg::TMR_ZERO : tmr_q + 4'h1;

	always_comb begin
		ctl_d       = bedo_seq_pkg::CTL_IDLE;
		ctl_d.ras_n = (state_d == bedo_seq_pkg::ST_IDLE) || (state_d == bedo_seq_pkg::ST_PRE);
		if (cas_all_d) begin
			ctl_d.cas_n = bedo_seq_pkg::LANES_OFF;
		end else if (cas_lane_d) begin
			ctl_d.cas_n = ~addr_d_lanes(state_d, be_d, cpu.byte_en);
		end
		// write-enable low on write strobes; on reads it is the abort toggle
		if (cas_lane_d) begin
			ctl_d.we_n = 1'b0;
		end else if (!write_q && state_d == bedo_seq_pkg::ST_ABORT) begin
			ctl_d.we_n = 1'b0;
		end
	end

	// lanes for a write strobe: the latched enables, fresh after the stalls
	function automatic logic [bedo_seq_pkg::LANES-1:0] addr_d_lanes(
		input bedo_seq_pkg::seq_state_type st,
		input logic [bedo_seq_pkg::LANES-1:0] latched,
		input logic [bedo_seq_pkg::LANES-1:0] live
	);
		addr_d_lanes = (st == bedo_seq_pkg::ST_WCAS) ? live : latched;
	endfunction

	assign rdata_d  = (state_q == bedo_seq_pkg::ST_RDBEAT) ? dram_dq_in : rdata_q;
	assign wdout_d  = cas_lane_d ? cpu_wdata : wdout_q;
	assign oe_n_d   = !cas_lane_d;
	assign wait_n_d = beat_done;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_q   <= bedo_seq_pkg::ST_IDLE;
			addr_q    <= bedo_seq_pkg::DATA_ZERO;
			be_q      <= bedo_seq_pkg::LANES_OFF;
			write_q   <= 1'b0;
			clf_q     <= 1'b0;
			aborted_q <= 1'b0;
			bcnt_q    <= bedo_seq_pkg::BCNT_ZERO;
			tmr_q     <= bedo_seq_pkg::TMR_ZERO;
			ctl_q     <= bedo_seq_pkg::CTL_IDLE;
			rdata_q   <= bedo_seq_pkg::DATA_ZERO;
			wdout_q   <= bedo_seq_pkg::DATA_ZERO;
			oe_n_q    <= 1'b1;
			wait_n_q  <= 1'b0;
		end else begin
			state_q   <= state_d;
			addr_q    <= addr_d;
			be_q      <= be_d;
			write_q   <= write_d;
			clf_q     <= clf_d;
			aborted_q <= aborted_d;
			bcnt_q    <= bcnt_d;
			tmr_q     <= tmr_d;
			ctl_q     <= ctl_d;
			rdata_q   <= rdata_d;
			wdout_q   <= wdout_d;
			oe_n_q    <= oe_n_d;
			wait_n_q  <= wait_n_d;
		end
	end

	assign cpu_rdata    = rdata_q;
	assign cpu_wait_n   = wait_n_q;
	assign dram_ctl     = ctl_q;
	assign dram_dq_out  = wdout_q;
	assign dram_dq_oe_n = oe_n_q;

	bedo_addr_mux u_addr_mux (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.use_col   (use_col_d),
		.addr      (addr_d),
		.dram_addr (dram_addr)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	chk_read_end_ras: assert property (
		(state_q == bedo_seq_pkg::ST_NEXT && !cpu_wait_n && !write_q && !cont
		&& !(clf_q && bcnt_zero && !aborted_q))
		|=> dram_ctl.ras_n ##1 dram_ctl.ras_n)
		else $error("row strobe not negated at read end");

	chk_first_lanes: assert property (
		(state_q == bedo_seq_pkg::ST_COL && write_q) |-> (dram_ctl.cas_n == ~be_q) && !dram_ctl.we_n)
		else $error("first write strobe lanes wrong");

	chk_write_abort: assert property (
		(state_q == bedo_seq_pkg::ST_COL && write_q)
		|=> dram_ctl.we_n && (dram_ctl.cas_n == 4'hf) && (state_q == bedo_seq_pkg::ST_ABORT))
		else $error("write burst not aborted after first beat");

	chk_write_stalls: assert property (
		(state_q == bedo_seq_pkg::ST_WCAS)
		|-> ($past(state_q, 1) == bedo_seq_pkg::ST_WSTL2) && ($past(state_q, 2) == bedo_seq_pkg::ST_WSTL1))
		else $error("write strobe without two stalls");

	chk_write_nocount: assert property (
		(state_q == bedo_seq_pkg::ST_NEXT && write_q && cont) |=> (state_q == bedo_seq_pkg::ST_WSTL1))
		else $error("write continuation depends on countdown");

	chk_fresh_column: assert property (
		(state_q == bedo_seq_pkg::ST_WCAS)
		|-> (dram_addr == addr_q[11:2]) && !dram_dq_oe_n && (dram_dq_out == $past(cpu_wdata)))
		else $error("write strobe without fresh column or data");

	chk_fill_load: assert property (
		(state_q == bedo_seq_pkg::ST_IDLE && cpu.mreq && cpu.clf && !cpu.write) |=> (bcnt_q == 2'h3))
		else $error("line fill countdown not loaded with three");

	chk_addr_strobe: assert property (
		(state_q == bedo_seq_pkg::ST_COL && !write_q) |=> !cpu_wait_n ##1 cpu_wait_n)
		else $error("address strobe mistaken for a data beat");

	chk_wrap_term: assert property (
		(state_q == bedo_seq_pkg::ST_NEXT && !cpu_wait_n && !write_q && clf_q && bcnt_zero && !aborted_q)
		|=> !dram_ctl.we_n && dram_ctl.cas_n == 4'hf)
		else $error("wrapped read not terminated");

	chk_cross_abort: assert property (
		(state_q == bedo_seq_pkg::ST_NEXT && !cpu_wait_n && !write_q && cont && bcnt_zero && !aborted_q)
		|=> (state_q == bedo_seq_pkg::ST_ABORT) ##1 (state_q == bedo_seq_pkg::ST_NEXT)
		##1 (state_q == bedo_seq_pkg::ST_COL))
		else $error("block crossing without abort");

	chk_wait_beat: assert property (
		cpu_wait_n |-> $past(beat_done))
		else $error("processor released without a beat");

	cov_line_fill: cover property (
		(state_q == bedo_seq_pkg::ST_IDLE && cpu.mreq && cpu.clf && !cpu.write) ##[1:40]
		(state_q == bedo_seq_pkg::ST_ABORT));
	cov_cross_read: cover property (
		(state_q == bedo_seq_pkg::ST_ABORT && !write_q) ##2 (state_q == bedo_seq_pkg::ST_COL));
	cov_write_seq: cover property (
		(state_q == bedo_seq_pkg::ST_WCAS) ##[1:20] (state_q == bedo_seq_pkg::ST_WCAS));

endmodule

`default_nettype wire

// ### logic/bedo_seq_pkg.sv
package bedo_seq_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int T_RCD_NS      = 15;
	localparam int T_RP_NS       = 30;
	localparam int RCD_CYC       = (T_RCD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RP_CYC        = (T_RP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int STALL_CYC     = 2;

	// ----------------------------------------------------------------
	// widths, fields, reset values
	// ----------------------------------------------------------------
	localparam int ADDR_W     = 32;
	localparam int DATA_W     = 32;
	localparam int LANES      = 4;
	localparam int DRAM_A_W   = 10;
	localparam int COL_LSB    = 2;
	localparam int ROW_LSB    = 12;
	localparam int BEAT_LSB   = 2;
	localparam int BCNT_W     = 2;
	localparam int TMR_W      = 4;
	localparam logic [1:0] BCNT_LINE  = 2'h3;
	localparam logic [1:0] BCNT_ZERO  = 2'h0;
	localparam logic [3:0] LANES_OFF  = 4'h0;
	localparam logic [3:0] TMR_ZERO   = 4'h0;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
	localparam logic [9:0] DADDR_ZERO = 10'h000;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'h0,
		ST_ROW    = 4'h1,
		ST_COL    = 4'h2,
		ST_RDBEAT = 4'h3,
		ST_NEXT   = 4'h4,
		ST_ABORT  = 4'h5,
		ST_WSTL1  = 4'h6,
		ST_WSTL2  = 4'h7,
		ST_WCAS   = 4'h8,
		ST_PRE    = 4'h9
	} seq_state_type;

	typedef struct packed {
		logic              mreq;
		logic              seq;
		logic              write;
		logic              clf;
		logic [LANES-1:0]  byte_en;
		logic [ADDR_W-1:0] addr;
	} cpu_req_type;

	typedef struct packed {
		logic             ras_n;
		logic [LANES-1:0] cas_n;
		logic             we_n;
	} dram_ctl_type;

	localparam dram_ctl_type CTL_IDLE = '{ras_n: 1'b1, cas_n: 4'hf, we_n: 1'b1};

endpackage

// ### sim/bedo_dram_model.sv
`timescale 1ns/1ps
`default_nettype none

module bedo_dram_model (
	input  wire logic                                clk_sys,
	input  wire bedo_seq_pkg::dram_ctl_type          dram_ctl,
	input  wire logic [bedo_seq_pkg::DRAM_A_W-1:0]   dram_addr,
	input  wire logic [bedo_seq_pkg::DATA_W-1:0]     dram_dq_out,
	output logic      [bedo_seq_pkg::DATA_W-1:0]     dram_dq_in
);
	// ----------------------------------------------------------------
	// burst device with one column counter per byte lane
	// ----------------------------------------------------------------
	logic [7:0]  mem [0:63][0:3];
	logic [5:0]  col_q [0:3];
	logic [5:0]  c;
	logic        need_addr_q;
	logic        we_prev_q;
	logic [31:0] last_q;
	logic [31:0] rd_word;
	logic        data_beat;

	// first read strobe after row or abort only takes the column; a first write strobe writes there
	assign data_beat  = !dram_ctl.ras_n && dram_ctl.cas_n != 4'hf && dram_ctl.we_n && !need_addr_q;
	assign rd_word    = {mem[col_q[3]][3], mem[col_q[2]][2], mem[col_q[1]][1], mem[col_q[0]][0]};
	// released bus shows the inverse of the last beat
	assign dram_dq_in = data_beat ? rd_word : ~last_q;

	initial begin
		for (int w = 0; w < 64; w++) begin
			for (int l = 0; l < 4; l++) begin
				mem[w][l] = w[7:0];
				col_q[l] = 6'h0;
			end
		end
		need_addr_q = 1'b1;
		we_prev_q = 1'b1;
		last_q = 32'h0000_0000;
	end

	always @(posedge clk_sys) begin
		we_prev_q <= dram_ctl.we_n;
		if (data_beat) begin
			last_q <= rd_word;
		end
		if (dram_ctl.ras_n || (dram_ctl.cas_n == 4'hf && dram_ctl.we_n != we_prev_q)) begin
			need_addr_q <= 1'b1;
		end else if (dram_ctl.cas_n != 4'hf) begin
			need_addr_q <= 1'b0;
			for (int l = 0; l < 4; l++) begin
				c = need_addr_q ? dram_addr[5:0] : col_q[l];
				if (!dram_ctl.cas_n[l] && !dram_ctl.we_n) begin
					mem[c][l] <= dram_dq_out[8*l +: 8];
				end
				if (!dram_ctl.cas_n[l] && (!need_addr_q || !dram_ctl.we_n)) begin
					col_q[l] <= {c[5:2], c[1:0] + 2'h1};
				end else begin
					col_q[l] <= c;
				end
			end
		end
	end
endmodule

`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic                      clk_sys;
	logic                      reset;
	bedo_seq_pkg::cpu_req_type cpu;
	logic [31:0]               cpu_wdata;
	logic [31:0]               cpu_rdata;
	logic                      cpu_wait_n;
	bedo_seq_pkg::dram_ctl_type dram_ctl;
	logic [9:0]                dram_addr;
	logic [31:0]               dram_dq_in;
	logic [31:0]               dram_dq_out;
	logic                      dram_dq_oe_n;
	int                        num_errors;
	int                        total_checks;
	int                        cycles;
	int                        strobes;
	int                        we_fall;
	int                        we_rise;
	logic                      we_prev;
	logic [3:0]                wr_cas [$];
	logic [9:0]                wr_adr [$];
	logic [3:0]                wbe [4] = '{4'h3, 4'h1, 4'hf, 4'hf};
	logic [31:0]               wdat [4] = '{32'h8899_aabb, 32'hccdd_eeff, 32'h1122_3344, 32'h0011_2233};
	logic [31:0]               rexp_x [4] = '{32'h0202_aabb, 32'h0303_03ff, 32'h1122_3344, 32'h0011_2233};
	logic [31:0]               rexp_f [4] = '{32'h0011_2233, 32'h0606_0606, 32'h0707_0707, 32'h1122_3344};
	logic [31:0]               fadr [4] = '{32'h0000_0014, 32'h0000_0018, 32'h0000_001c, 32'h0000_0010};

	bedo_dram_burst_sequencer uut (.clk_sys(clk_sys), .reset(reset), .cpu(cpu), .cpu_wdata(cpu_wdata),
		.cpu_rdata(cpu_rdata), .cpu_wait_n(cpu_wait_n), .dram_ctl(dram_ctl), .dram_addr(dram_addr),
		.dram_dq_in(dram_dq_in), .dram_dq_out(dram_dq_out), .dram_dq_oe_n(dram_dq_oe_n));

	bedo_dram_model dram (.clk_sys(clk_sys), .dram_ctl(dram_ctl), .dram_addr(dram_addr),
		.dram_dq_out(dram_dq_out), .dram_dq_in(dram_dq_in));

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// ----------------------------------------------------------------
	// strobe and write-enable monitor, hang limit
	// ----------------------------------------------------------------
	always @(posedge clk_sys) begin
		cycles++;
		we_prev <= dram_ctl.we_n;
		if (dram_ctl.cas_n !== 4'hf) begin
			strobes++;
		end
		if (dram_ctl.cas_n === 4'hf && dram_ctl.we_n === 1'b0 && we_prev === 1'b1) begin
			we_fall++;
		end
		if (dram_ctl.cas_n === 4'hf && dram_ctl.we_n === 1'b1 && we_prev === 1'b0) begin
			we_rise++;
		end
		if (dram_ctl.cas_n !== 4'hf && dram_ctl.we_n === 1'b0) begin
			wr_cas.push_back(dram_ctl.cas_n);
			wr_adr.push_back(dram_addr);
			check({31'h0, dram_dq_oe_n}, 32'h0000_0000);
		end
		if (cycles == 2000) begin
			num_errors++;
			close_out();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one processor beat, held until the wait pulse is seen
	task automatic beat(input logic wr, input logic cl, input logic sq, input logic [3:0] be,
		input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd, output int waited);
		cpu <= '{mreq: 1'b1, seq: sq, write: wr, clf: cl, byte_en: be, addr: a};
		cpu_wdata <= wd;
		waited = 0;
		do begin
			@(posedge clk_sys);
			waited++;
		end while (cpu_wait_n !== 1'b1 && waited < 40);
		rd = cpu_rdata;
	endtask

	task automatic end_burst(output int to_ras);
		cpu <= '0;
		to_ras = 0;
		do begin
			@(posedge clk_sys);
			to_ras++;
		end while (dram_ctl.ras_n !== 1'b1 && to_ras < 20);
		repeat (10) @(posedge clk_sys);
	endtask

	task automatic wr_seq();
		logic [31:0] rd;
		int          w;
		int          r0;
		r0 = we_rise;
		wr_cas.delete();
		wr_adr.delete();
		for (int i = 0; i < 4; i++) begin
			beat(1'b1, 1'b0, i != 0, wbe[i], 32'h8 + 32'(4 * i), wdat[i], rd, w);
			if (i != 0) begin
				check(32'(w), 32'h0000_0005);
			end
		end
		end_burst(w);
		for (int i = 0; i < 4; i++) begin
			check({28'h0, wr_cas[i]}, {28'h0, ~wbe[i]});
			check({22'h0, wr_adr[i]}, 32'(2 + i));
		end
		check(32'(wr_cas.size()), 32'h0000_0004);
		check(32'(we_rise - r0), 32'h0000_0004);
	endtask

	task automatic rd_burst(input logic cl, input int exp_fall, input int exp_strobes);
		logic [31:0] rd;
		int          w;
		int          s0;
		int          f0;
		s0 = strobes;
		f0 = we_fall;
		for (int i = 0; i < 4; i++) begin
			beat(1'b0, cl, i != 0, 4'hf, cl ? fadr[i] : 32'h8 + 32'(4 * i), 32'h0, rd, w);
			check(rd, cl ? rexp_f[i] : rexp_x[i]);
		end
		end_burst(w);
		check(32'(w), cl ? 32'h0000_0004 : 32'h0000_0002);
		check(32'(strobes - s0), 32'(exp_strobes));
		check(32'(we_fall - f0), 32'(exp_fall));
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		reset = 1'b1;
		cpu = '0;
		cpu_wdata = 32'h0000_0000;
		num_errors = 0;
		total_checks = 0;
		cycles = 0;
		strobes = 0;
		we_fall = 0;
		we_rise = 0;
		we_prev = 1'b1;
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (2) @(posedge clk_sys);
		check({25'h0, dram_ctl}, {25'h0, bedo_seq_pkg::CTL_IDLE});
		wr_seq();
		rd_burst(1'b0, 1, 6);
		rd_burst(1'b1, 1, 5);
		close_out();
	end
endmodule

`default_nettype wire
